/* File: rtl/fswp_core.sv */
`timescale 1ns/1ns
module fswp_core #(
    parameter int PROG_CYC  = fswp_pkg::FSWP_PROG_CYC,
    parameter int ERASE_CYC = fswp_pkg::FSWP_ERASE_CYC
) (
    input  logic                 clk_sys,
    input  logic                 reset,
    input  logic                 clk_en,
    input  fswp_pkg::fswp_pins_t pins,
    output logic [15:0]          dq_out,
    output logic                 dq_oe,
    output logic                 standby
);
    import fswp_pkg::*;

    fswp_state_t s_q;
    fswp_state_t s_d;
    logic [1:0]  pa;
    logic [7:0]  cmd;
    logic        wr;
    logic        rd;
    logic        fall;
    logic        busy;
    logic [7:0]  sr_pa;
    logic [7:0]  sr_op;
    logic [7:0]  sr_nx;

    ////////////////////////////////////////////////////////////////////////////
    // Status byte as seen from partition p.
    function automatic logic [7:0] sr_of(input fswp_state_t s, input logic [1:0] p);
        logic [7:0] r;
        logic       b;
        b = (s.op != OP_IDLE) && !s.psusp;
        r = FSWP_SR_RST;
        r[FSWP_SR_READY] = !b;
        r[FSWP_SR_ESUSP] = s.esv && (s.espart == p);
        r[FSWP_SR_EFAIL] = s.err[p][FSWP_ERR_E];
        r[FSWP_SR_PFAIL] = s.err[p][FSWP_ERR_P];
        r[FSWP_SR_VLOW]  = s.err[p][FSWP_ERR_V];
        r[FSWP_SR_PSUSP] = (s.op == OP_PROG) && s.psusp && (s.oaddr[5:4] == p);
        r[FSWP_SR_LOCK]  = s.err[p][FSWP_ERR_L];
        if (s.op == OP_EFP) begin
            r[FSWP_SR_PBUSY] = b && (s.cnt != 16'h0000);
        end else begin
            r[FSWP_SR_PBUSY] = b && (s.oaddr[5:4] != p);
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus events decoded from the synchronised pins.
    assign pa    = s_q.p2.addr[5:4];
    assign cmd   = s_q.p2.dq[7:0];
    assign busy  = (s_q.op != OP_IDLE) && !s_q.psusp;
    assign wr    = !s_q.p2.ce_n && !s_q.prev[0] && s_q.p2.we_n;
    assign rd    = !s_q.p2.ce_n && !s_q.p2.oe_n && s_q.p2.we_n;
    assign fall  = rd && (s_q.prev[2] || s_q.prev[1]);
    assign sr_pa = sr_of(s_q, pa);
    assign sr_op = sr_of(s_q, s_q.oaddr[5:4]);
    assign sr_nx = sr_of(s_q, s_q.oaddr[5:4] + 2'd1); // Seen from the next partition.

    // Outputs; standby is held off while the machine works.
    assign dq_out  = s_q.dq;
    assign dq_oe   = rd;
    assign standby = s_q.p2.ce_n && !busy;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: pin sync, operation timing, then command writes.
    always_comb begin
        s_d      = s_q;
        s_d.p1   = pins;
        s_d.p2   = s_q.p1;
        s_d.prev = {s_q.p2.ce_n, s_q.p2.oe_n, s_q.p2.we_n};

        // Running operation counts down and finishes.
        if (busy && s_q.cnt != 16'h0000) begin
            s_d.cnt = s_q.cnt - 16'h0001;
            if (s_q.cnt == 16'h0001) begin
                case (s_q.op)
                    OP_PROG: begin
                        s_d.op = OP_IDLE;
                        if (!s_q.p2.vpp_ok) begin
                            s_d.err[s_q.oaddr[5:4]][FSWP_ERR_V] = 1'b1;
                        end else if (s_q.p2.cell_fault) begin
                            s_d.err[s_q.oaddr[5:4]][FSWP_ERR_P] = 1'b1;
                        end else begin
                            s_d.mem_n[s_q.oaddr] = s_q.mem_n[s_q.oaddr] | ~s_q.odata;
                        end
                    end
                    OP_ERASE: begin
                        s_d.op = OP_IDLE;
                        if (!s_q.p2.vpp_ok) begin
                            s_d.err[s_q.oaddr[5:4]][FSWP_ERR_V] = 1'b1;
                        end else if (s_q.p2.cell_fault) begin
                            s_d.err[s_q.oaddr[5:4]][FSWP_ERR_E] = 1'b1;
                        end else begin
                            for (int i = 0; i < 16; i++) begin
                                s_d.mem_n[{s_q.oaddr[5:4], 4'(i)}] = 16'h0000;
                            end
                        end
                    end
                    OP_EFP: begin
                        s_d.efp_go = 1'b1;
                        if (!s_q.p2.vpp_ok) begin
                            s_d.err[s_q.oaddr[5:4]][FSWP_ERR_V] = 1'b1;
                            s_d.op = OP_IDLE;
                        end else if (s_q.efp_go) begin
                            if (s_q.p2.cell_fault) begin
                                s_d.err[s_q.oaddr[5:4]][FSWP_ERR_P] = 1'b1;
                            end else begin
                                s_d.mem_n[s_q.oaddr] = s_q.mem_n[s_q.oaddr] | ~s_q.odata;
                            end
                            s_d.oaddr = {s_q.oaddr[5:4], s_q.oaddr[3:0] + 4'h1};
                        end
                    end
                    default: begin
                        s_d.op = OP_IDLE;
                    end
                endcase
            end
        end

        // Second cycle of a two-cycle command.
        if (wr && s_q.pend != PD_NONE) begin
            s_d.pend     = PD_NONE;
            s_d.mode[pa] = MD_STATUS;
            case (s_q.pend)
                PD_PGM: begin
                    if (s_q.op != OP_IDLE) begin
                        s_d.err[pa][FSWP_ERR_E] = 1'b1;
                        s_d.err[pa][FSWP_ERR_P] = 1'b1;
                    end else if (s_q.p2.lock[pa]) begin
                        s_d.err[pa][FSWP_ERR_L] = 1'b1;
                    end else begin
                        s_d.op    = OP_PROG;
                        s_d.psusp = 1'b0;
                        s_d.oaddr = s_q.p2.addr;
                        s_d.odata = s_q.p2.dq;
                        s_d.cnt   = 16'(PROG_CYC);
                    end
                end
                PD_ERS, PD_EFP: begin
                    if (cmd != FSWP_CMD_CONF || s_q.op != OP_IDLE || s_q.esv) begin
                        s_d.err[pa][FSWP_ERR_E] = 1'b1;
                        s_d.err[pa][FSWP_ERR_P] = 1'b1;
                    end else if (s_q.p2.lock[pa]) begin
                        s_d.err[pa][FSWP_ERR_L] = 1'b1;
                    end else if (s_q.pend == PD_ERS) begin
                        s_d.op    = OP_ERASE;
                        s_d.oaddr = s_q.p2.addr;
                        s_d.cnt   = 16'(ERASE_CYC);
                    end else begin
                        s_d.op      = OP_EFP;
                        s_d.efp_go  = 1'b0;
                        s_d.efp_vfy = 1'b0;
                        s_d.oaddr   = s_q.p2.addr;
                        s_d.w0      = s_q.p2.addr;
                        s_d.odata   = 16'hffff;
                        s_d.cnt     = 16'(PROG_CYC);
                    end
                end
                default: begin
                    s_d.pend = PD_NONE;
                end
            endcase
        end else if (wr && s_q.op == OP_EFP) begin
            // Stream writes; a write of all ones outside the block ends a phase.
            if (pa != s_q.oaddr[5:4]) begin
                if (s_q.p2.dq == 16'hffff && s_q.cnt == 16'h0000) begin
                    if (s_q.efp_vfy) begin
                        s_d.op = OP_IDLE;
                    end else begin
                        s_d.efp_vfy = 1'b1;
                        s_d.oaddr   = s_q.w0;
                    end
                end
            end else if (s_q.cnt == 16'h0000 && s_q.efp_go) begin
                if (s_q.p2.addr != s_q.w0) begin
                    s_d.oaddr = s_q.p2.addr;
                end
                s_d.odata = s_q.p2.dq;
                s_d.cnt   = 16'(PROG_CYC);
            end
        end else if (wr) begin
            // Single-cycle commands; a busy machine takes only a few.
            if (cmd == FSWP_CMD_RSTAT) begin
                s_d.mode[pa] = MD_STATUS;
            end else if (cmd == FSWP_CMD_ARRAY) begin
                s_d.mode[pa] = MD_ARRAY;
            end else if (cmd == FSWP_CMD_IDENT) begin
                s_d.mode[pa] = MD_IDENT;
            end else if (cmd == FSWP_CMD_QUERY) begin
                s_d.mode[pa] = MD_QUERY;
            end else if (cmd == FSWP_CMD_SUSP) begin
                if (s_q.op == OP_PROG) begin
                    s_d.psusp = 1'b1;
                end else if (s_q.op == OP_ERASE && s_d.op == OP_ERASE) begin
                    s_d.op     = OP_IDLE;
                    s_d.esv    = 1'b1;
                    s_d.espart = s_q.oaddr[5:4];
                    s_d.escnt  = s_q.cnt;
                end
            end else if (busy) begin
                s_d.pend = PD_NONE;
            end else if (cmd == FSWP_CMD_CLR) begin
                s_d.err = '0;
            end else if (cmd == FSWP_CMD_CONF) begin
                if (s_q.op == OP_PROG) begin
                    s_d.psusp = 1'b0;
                end else if (s_q.op == OP_IDLE && s_q.esv) begin
                    s_d.op    = OP_ERASE;
                    s_d.esv   = 1'b0;
                    s_d.oaddr = {s_q.espart, 4'h0};
                    s_d.cnt   = s_q.escnt;
                end
            end else if (cmd == FSWP_CMD_PGM1 || cmd == FSWP_CMD_PGM2) begin
                s_d.pend = PD_PGM;
            end else if (cmd == FSWP_CMD_ERASE) begin
                s_d.pend = PD_ERS;
            end else if (cmd == FSWP_CMD_EFP) begin
                s_d.pend = PD_EFP;
            end else begin
                s_d.err[pa][FSWP_ERR_E] = 1'b1;
                s_d.err[pa][FSWP_ERR_P] = 1'b1;
            end
        end

        // Read data: status latched on each select or enable fall.
        if (rd) begin
            case (s_q.mode[pa])
                MD_STATUS: begin
                    if (fall) begin
                        s_d.dq = {8'h00, sr_pa};
                    end
                end
                MD_ARRAY: begin
                    s_d.dq = ~s_q.mem_n[s_q.p2.addr];
                end
                default: begin
                    s_d.dq = 16'h0000;
                end
            endcase
        end

        // Device reset pin clears status and aborts all work.
        if (!s_q.p2.rst_n) begin
            s_d.err   = '0;
            s_d.op    = OP_IDLE;
            s_d.psusp = 1'b0;
            s_d.esv   = 1'b0;
            s_d.pend  = PD_NONE;
            s_d.mode  = '0;
            s_d.cnt   = 16'h0000;
            s_d.dq    = 16'h0000;
        end
    end

    // State register with synchronous reset and clock enable.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the state machine and status byte.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    busy_ready_a: assert property (busy |-> !sr_op[FSWP_SR_READY])
        else $error("ready bit high while busy");
    own_busy_a: assert property (
        (s_q.op == OP_PROG || s_q.op == OP_ERASE) && busy
        |-> !sr_op[FSWP_SR_PBUSY] && sr_nx[FSWP_SR_PBUSY])
        else $error("partition busy bit wrong");
    erase_susp_a: assert property (
        clk_en && wr && s_q.pend == PD_NONE && cmd == FSWP_CMD_SUSP
        && s_q.op == OP_ERASE && s_q.cnt > 16'h0001 && s_q.p2.rst_n
        |=> s_q.esv && !busy)
        else $error("erase suspend not taken");
    prog_susp_a: assert property (
        s_q.op == OP_PROG && s_q.psusp
        |-> sr_op[FSWP_SR_PSUSP] && sr_op[FSWP_SR_READY])
        else $error("program suspend flags missing");
    bad_seq_a: assert property (
        clk_en && wr && s_q.pend == PD_ERS && cmd != FSWP_CMD_CONF && s_q.p2.rst_n
        |=> s_q.err[$past(pa)][FSWP_ERR_E] && s_q.err[$past(pa)][FSWP_ERR_P])
        else $error("sequence error not flagged");
    sticky_err_a: assert property (
        clk_en && s_q.p2.rst_n
        && !(wr && !busy && s_q.pend == PD_NONE && s_q.op != OP_EFP && cmd == FSWP_CMD_CLR)
        |=> (s_q.err & $past(s_q.err)) == $past(s_q.err))
        else $error("error bit lost without clear");
    status_lat_a: assert property (
        clk_en && fall && s_q.mode[pa] == MD_STATUS && s_q.p2.rst_n
        |=> dq_out == {8'h00, $past(sr_pa)})
        else $error("status not refreshed on fall");
    no_standby_a: assert property (s_q.op == OP_PROG && !s_q.psusp |-> !standby)
        else $error("standby during program");
    prog_hold_a: assert property (
        clk_en && busy && s_q.op == OP_PROG && s_q.cnt > 16'h0001
        && s_q.p2.rst_n && !(wr && cmd == FSWP_CMD_SUSP) |=> s_q.op == OP_PROG)
        else $error("program ended early");
    reset_clr_a: assert property (clk_en && !s_q.p2.rst_n |=> s_q.err == '0 && !busy)
        else $error("device reset left status");
endmodule

/* File: rtl/fswp_pkg.sv */
package fswp_pkg;
// Contract
// - Bit 7 reads 0 while program or erase runs, 1 when ready.
// - Erase suspend halts the machine, sets bits 7 and 6 until resume.
// - A failed block erase sets bit 5.
// - A bad command sequence sets bits 5 and 4 together.
// - A failed word program sets bit 4.
// - Bit 3 flags low program supply, sampled only at completion.
// - Program suspend halts the machine, sets bits 7 and 2 until resume.
// - Program or erase on a locked block aborts and sets bit 1.
// - Bit 0 tells own versus other partition busy; 1/1 never shows.
// - In fast factory program bit 0 shows the stream word still busy.
// - Clear status resets the flags and leaves every output mode alone.
// - Machine clears only bits 7, 6, 2, 0; error bits stay until cleared.
// - The active-low device reset clears the status register.
// - Clear status works whatever the program supply level.
// - Programming only turns ones to zeros: new word is old AND data.
// - One partition programs at a time; one erase may be suspended.
// - Bit 7 is device-wide, other bits belong to the addressed partition.
// - Each chip-select or output-enable fall refreshes the shown status.
// - While programming accept status, suspend, identifier, query, array.
// - After a program the partition stays in status output mode.
// - Standby waits while a program is running with chip select high.
// - Status reads drive bits 7..0 with zeros on lines 15..8.
// - Word program opens with either of two codes, then address and data.
// - Program, erase or lock sequences switch the partition to status mode.

localparam int FSWP_CLK_MHZ   = 125;
localparam int FSWP_PROG_NS   = 8000;
localparam int FSWP_ERASE_NS  = 40000;
localparam int FSWP_PROG_CYC  = (FSWP_PROG_NS * FSWP_CLK_MHZ + 999) / 1000;
localparam int FSWP_ERASE_CYC = (FSWP_ERASE_NS * FSWP_CLK_MHZ + 999) / 1000;

// Status bit positions and sticky error slots.
localparam int FSWP_SR_READY = 7;
localparam int FSWP_SR_ESUSP = 6;
localparam int FSWP_SR_EFAIL = 5;
localparam int FSWP_SR_PFAIL = 4;
localparam int FSWP_SR_VLOW  = 3;
localparam int FSWP_SR_PSUSP = 2;
localparam int FSWP_SR_LOCK  = 1;
localparam int FSWP_SR_PBUSY = 0;
localparam int FSWP_ERR_E    = 3;
localparam int FSWP_ERR_P    = 2;
localparam int FSWP_ERR_V    = 1;
localparam int FSWP_ERR_L    = 0;
localparam logic [7:0] FSWP_SR_RST = 8'h00;

// Command codes.
localparam logic [7:0] FSWP_CMD_PGM1  = 8'h40;
localparam logic [7:0] FSWP_CMD_PGM2  = 8'h10;
localparam logic [7:0] FSWP_CMD_ERASE = 8'h20;
localparam logic [7:0] FSWP_CMD_EFP   = 8'h30;
localparam logic [7:0] FSWP_CMD_CONF  = 8'hd0;
localparam logic [7:0] FSWP_CMD_SUSP  = 8'hb0;
localparam logic [7:0] FSWP_CMD_RSTAT = 8'h70;
localparam logic [7:0] FSWP_CMD_CLR   = 8'h50;
localparam logic [7:0] FSWP_CMD_ARRAY = 8'hff;
localparam logic [7:0] FSWP_CMD_IDENT = 8'h90;
localparam logic [7:0] FSWP_CMD_QUERY = 8'h98;

typedef enum logic [1:0] {MD_ARRAY, MD_STATUS, MD_IDENT, MD_QUERY} fswp_mode_t;
typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE, OP_EFP} fswp_op_t;
typedef enum logic [1:0] {PD_NONE, PD_PGM, PD_ERS, PD_EFP} fswp_pend_t;

// Flash bus pins and supply/cell conditions, all asynchronous.
typedef struct packed {
    logic        rst_n;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [5:0]  addr;
    logic [15:0] dq;
    logic        vpp_ok;
    logic        cell_fault;
    logic [3:0]  lock;
} fswp_pins_t;

typedef struct packed {
    fswp_pins_t          p1;
    fswp_pins_t          p2;
    logic [2:0]          prev;
    fswp_pend_t          pend;
    fswp_op_t            op;
    logic                psusp;
    logic                efp_go;
    logic                efp_vfy;
    logic [5:0]          oaddr;
    logic [5:0]          w0;
    logic [15:0]         odata;
    logic [15:0]         cnt;
    logic                esv;
    logic [1:0]          espart;
    logic [15:0]         escnt;
    fswp_mode_t [3:0]    mode;
    logic [3:0][3:0]     err;
    logic [15:0]         dq;
    logic [63:0][15:0]   mem_n;
} fswp_state_t;

endpackage

/* File: tb/fswp_host.sv */
`timescale 1ns/1ns
// Host processor model that works the parallel flash bus.
module fswp_host (
    input  logic                 clk_sys,
    input  logic [15:0]          dq_out,
    input  logic                 dq_oe,
    output fswp_pkg::fswp_pins_t pins,
    output logic                 rd_valid,
    output logic [15:0]          rd_data
);
    import fswp_pkg::*;

    // Bus idle and supply good from time zero.
    initial begin
        pins = '{rst_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 6'h00,
                 dq: 16'h0000, vpp_ok: 1'b1, cell_fault: 1'b0, lock: 4'h0};
        rd_valid = 1'b0;
        rd_data  = 16'h0000;
    end

    // Waits a number of clock edges.
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One write; address and data stay put well past the write-enable rise.
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        pins.ce_n <= 1'b0;
        pins.we_n <= 1'b0;
        pins.addr <= a;
        pins.dq   <= d;
        idle(4);
        pins.we_n <= 1'b1;
        idle(4);
        pins.ce_n <= 1'b1;
        pins.dq   <= ~d; // A released bus shows no stale word.
        idle(4);
    endtask

    // One read; the settled word is handed on with a one-cycle strobe.
    task automatic rd(input logic [5:0] a);
        @(posedge clk_sys);
        pins.addr <= a;
        pins.ce_n <= 1'b0;
        pins.oe_n <= 1'b0;
        idle(6);
        rd_data  <= (dq_oe === 1'b1) ? dq_out : 16'hxxxx;
        rd_valid <= 1'b1;
        idle(1);
        rd_valid  <= 1'b0;
        pins.ce_n <= 1'b1;
        pins.oe_n <= 1'b1;
        idle(3);
    endtask

    // Sets supply, cell and lock conditions.
    task automatic cond(input logic v, input logic f, input logic [3:0] l);
        @(posedge clk_sys);
        pins.vpp_ok     <= v;
        pins.cell_fault <= f;
        pins.lock       <= l;
    endtask

    // Pulses the device reset pin.
    task automatic pulse_rst();
        @(posedge clk_sys);
        pins.rst_n <= 1'b0;
        idle(6);
        pins.rst_n <= 1'b1;
        idle(6);
    endtask
endmodule

/* File: tb/flash_status_and_word_program_bench.sv */
`timescale 1ns/1ns
module flash_status_and_word_program_bench;
    import fswp_pkg::*;

    localparam int PCYC = 60;
    localparam int ECYC = 80;

    logic        clk_sys  = 1'b0;
    logic        reset    = 1'b1;
    fswp_pins_t  pins;
    logic [15:0] dq_out;
    logic        dq_oe;
    logic        standby;
    logic        rd_valid;
    logic [15:0] rd_data;
    logic [15:0] exq[$];
    logic [15:0] d;
    logic [15:0] m;
    logic [15:0] e;
    logic [7:0]  codes[2] = '{FSWP_CMD_PGM1, FSWP_CMD_PGM2};
    int          errors   = 0;
    int          compares = 0;

    // Clock of 8 ns period.
    always #4 clk_sys = ~clk_sys;

    fswp_core #(.PROG_CYC(PCYC), .ERASE_CYC(ECYC)) dut (
        .clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .pins(pins),
        .dq_out(dq_out), .dq_oe(dq_oe), .standby(standby));

    fswp_host host (.clk_sys(clk_sys), .dq_out(dq_out), .dq_oe(dq_oe), .pins(pins),
                    .rd_valid(rd_valid), .rd_data(rd_data));

    // Compares every read word with the oldest expectation.
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            compares++;
            if (exq.size() == 0) begin
                errors++;
                $display("mismatch at %0t: read %h with no expectation", $time, rd_data);
            end else begin
                e = exq.pop_front();
                if (rd_data !== e) begin
                    errors++;
                    $display("mismatch at %0t: read %h expected %h", $time, rd_data, e);
                end
            end
        end
    end

    // Notes an expected word and reads it.
    task automatic chk(input logic [5:0] a, input logic [15:0] x);
        exq.push_back(x);
        host.rd(a);
    endtask

    // Checks the standby output.
    task automatic sby(input logic x);
        compares++;
        if (standby !== x) begin
            errors++;
            $display("mismatch at %0t: standby %b", $time, standby);
        end
    endtask

    // Two-cycle word program; only one partition programs at a time.
    task automatic prog(input logic [7:0] c, input logic [5:0] a, input logic [15:0] v);
        host.wr(a, {8'h00, c});
        host.wr(a, v);
    endtask

    // Clears status after an error was seen.
    task automatic clr(input logic [5:0] a);
        host.wr(a, {8'h00, FSWP_CMD_CLR});
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end

    // Main test sequence.
    initial begin
        void'($urandom(32'ha742c4e4));
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        host.idle(6);
        host.wr(6'h00, {8'h00, FSWP_CMD_RSTAT});
        chk(6'h00, 16'h0080);
        $display("test reset done");
        m = 16'hffff;
        foreach (codes[i]) begin
            d = 16'($urandom);
            prog(codes[i], 6'h03, d);
            chk(6'h03, 16'h0000);
            host.wr(6'h13, {8'h00, FSWP_CMD_RSTAT});
            chk(6'h13, 16'h0001);
            sby(1'b0);
            host.idle(PCYC);
            sby(1'b1);
            chk(6'h03, 16'h0080);
            host.wr(6'h03, {8'h00, FSWP_CMD_ARRAY});
            m = m & d;
            chk(6'h03, m);
        end
        $display("test program done");
        host.cond(1'b1, 1'b0, 4'h4);
        prog(FSWP_CMD_PGM1, 6'h21, 16'h1234);
        chk(6'h21, 16'h0082);
        host.cond(1'b1, 1'b0, 4'h0);
        prog(FSWP_CMD_PGM1, 6'h21, 16'h1234);
        host.idle(PCYC + 10);
        chk(6'h21, 16'h0082);
        clr(6'h21);
        chk(6'h21, 16'h0080);
        host.cond(1'b0, 1'b0, 4'h0);
        prog(FSWP_CMD_PGM1, 6'h22, 16'h0f0f);
        host.idle(PCYC + 10);
        chk(6'h22, 16'h0088);
        clr(6'h22);
        chk(6'h22, 16'h0080);
        host.cond(1'b1, 1'b1, 4'h0);
        host.wr(6'h22, {8'h00, FSWP_CMD_ARRAY});
        chk(6'h22, 16'hffff);
        prog(FSWP_CMD_PGM2, 6'h23, 16'h00f0);
        host.idle(PCYC + 10);
        chk(6'h23, 16'h0090);
        host.wr(6'h30, {8'h00, FSWP_CMD_ERASE});
        host.wr(6'h30, {8'h00, FSWP_CMD_CONF});
        host.idle(ECYC + 10);
        chk(6'h30, 16'h00a0);
        host.cond(1'b1, 1'b0, 4'h0);
        clr(6'h30);
        host.wr(6'h10, 16'h0033);
        host.wr(6'h10, {8'h00, FSWP_CMD_RSTAT});
        chk(6'h10, 16'h00b0);
        clr(6'h10);
        host.wr(6'h10, {8'h00, FSWP_CMD_ERASE});
        host.wr(6'h10, {8'h00, FSWP_CMD_ARRAY});
        chk(6'h10, 16'h00b0);
        clr(6'h10);
        $display("test errors done");
        prog(FSWP_CMD_PGM2, 6'h35, d);
        host.idle(PCYC + 10);
        host.wr(6'h30, {8'h00, FSWP_CMD_ERASE});
        host.wr(6'h30, {8'h00, FSWP_CMD_CONF});
        host.wr(6'h30, {8'h00, FSWP_CMD_SUSP});
        chk(6'h30, 16'h00c0);
        host.wr(6'h30, {8'h00, FSWP_CMD_CONF});
        chk(6'h30, 16'h0000);
        host.idle(ECYC);
        host.wr(6'h35, {8'h00, FSWP_CMD_ARRAY});
        chk(6'h35, 16'hffff);
        prog(FSWP_CMD_PGM1, 6'h02, 16'h5555);
        host.wr(6'h02, {8'h00, FSWP_CMD_SUSP});
        chk(6'h02, 16'h0084);
        host.wr(6'h02, {8'h00, FSWP_CMD_CONF});
        chk(6'h02, 16'h0000);
        host.idle(PCYC);
        chk(6'h02, 16'h0080);
        $display("test suspend done");
        host.wr(6'h18, {8'h00, FSWP_CMD_EFP});
        host.wr(6'h18, {8'h00, FSWP_CMD_CONF});
        host.idle(PCYC + 10);
        chk(6'h18, 16'h0000);
        // First pass programs two stream words, second pass programs them again in the verify phase.
        repeat (2) begin
            host.wr(6'h18, d);
            chk(6'h18, 16'h0001);
            host.idle(PCYC);
            host.wr(6'h18, ~d);
            host.idle(PCYC);
            host.wr(6'h30, 16'hffff);
        end
        chk(6'h18, 16'h0080);
        host.wr(6'h18, {8'h00, FSWP_CMD_IDENT});
        chk(6'h18, 16'h0000);
        host.wr(6'h18, {8'h00, FSWP_CMD_ARRAY});
        chk(6'h18, d);
        chk(6'h19, ~d);
        $display("test factory program done");
        host.cond(1'b1, 1'b0, 4'h1);
        prog(FSWP_CMD_PGM1, 6'h04, 16'h0000);
        chk(6'h04, 16'h0082);
        host.pulse_rst();
        host.cond(1'b1, 1'b0, 4'h0);
        host.wr(6'h04, {8'h00, FSWP_CMD_RSTAT});
        chk(6'h04, 16'h0080);
        $display("test device reset done");
        if (exq.size() != 0) begin
            errors++;
            $display("mismatch at %0t: reads missing", $time);
        end
        summarize();
    end
endmodule
